//--- common/sfd_pkg.sv
/*
  Shared constants for the framed single-wire register slave: frame fields,
  CRC settings, register offsets and reset values, counter widths.
  Assumes a 100 MHz core clock.
*/
package sfd_pkg;
    localparam int CLK_MHZ = 100;
    localparam int IDLE_UNIT_US = 100;
    localparam int IDLE_UNIT_CYCLES = IDLE_UNIT_US * CLK_MHZ;
    localparam int IDLE_W = 24;

    localparam logic [7:0] SYNC_PATTERN = 8'h55;
    localparam logic [7:0] CRC_INIT = 8'hFF;
    localparam logic [7:0] CRC_POLY_DEFAULT = 8'h2F;
    localparam int MAX_PAYLOAD = 24;

    // Device-select byte fields
    localparam int SEL_ADDR_LSB = 0;
    localparam int SEL_LEN_LSB = 4;
    localparam int SEL_BCAST_BIT = 6;
    localparam int SEL_WRITE_BIT = 7;
    localparam logic [3:0] BCAST_ADDR = 4'h0;

    // Sync measurement: falling edges after the start edge span 8 bit times
    localparam logic [2:0] SYNC_EDGES = 3'h4;
    localparam int MEAS_W = 18;
    localparam int BIT_W = MEAS_W - 3;

    // APB register offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STAT_OFS = 12'h004;
    localparam logic [11:0] CNT_OFS = 12'h008;

    // Control register fields and reset values
    localparam int CTRL_ADDRSRC_BIT = 0;
    localparam int CTRL_SLVADDR_LSB = 4;
    localparam int CTRL_RSPEN_BIT = 8;
    localparam int CTRL_IDLE_LSB = 12;
    localparam logic ADDRSRC_RST = 1'b0;
    localparam logic [3:0] SLVADDR_RST = 4'h0;
    localparam logic RSPEN_RST = 1'b1;
    localparam logic [3:0] IDLE_RST = 4'h3;

    function automatic logic [4:0] payload_len(input logic [1:0] code);
        case (code)
            2'b00: payload_len = 5'h01;
            2'b01: payload_len = 5'h04;
            2'b10: payload_len = 5'h10;
            default: payload_len = 5'h18;
        endcase
    endfunction : payload_len
endpackage : sfd_pkg

//--- hdl/sync_byte_rx.sv
/*
  Byte receiver with bit timing learned from the sync byte.
  Assumes rxLine is already synchronised to mclk and that restart is
  held by the owner while the received stream must be disregarded.
*/
`timescale 1ns/10ps
module sync_byte_rx
    import sfd_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Line and control
    input wire logic rxLine,
    input wire logic restart,
    // Received bytes and timing
    output logic byteValid,
    output logic [7:0] byteData,
    output logic locked,
    output logic [BIT_W-1:0] bitLen
);
    typedef enum logic [2:0] {RX_HUNT, RX_MEAS, RX_STOPWAIT, RX_IDLE, RX_HALF, RX_BITS,
        RX_STOP} rx_state_t;

    typedef struct packed {
        rx_state_t st;
        logic prevLine;
        logic [MEAS_W-1:0] cnt;
        logic [2:0] edges;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic valid;
        logic [7:0] data;
        logic locked;
        logic [BIT_W-1:0] bitLen;
    } rx_regs_t;

    rx_regs_t rx_ff;
    rx_regs_t nxt_rx;
    logic fall;
    logic [MEAS_W-1:0] bitFull;

    assign bitFull = {3'h0, rx_ff.bitLen};

    always_comb begin
        nxt_rx = rx_ff;
        nxt_rx.valid = 1'b0;
        nxt_rx.prevLine = rxLine;
        fall = rx_ff.prevLine & ~rxLine;
        if (restart) begin
            nxt_rx.st = RX_HUNT;
            nxt_rx.locked = 1'b0;
        end else begin
            case (rx_ff.st)
                RX_HUNT: begin
                    if (fall) begin
                        nxt_rx.st = RX_MEAS;
                        nxt_rx.cnt = {{(MEAS_W-1){1'b0}}, 1'b1};
                        nxt_rx.edges = 3'h0;
                    end
                end
                RX_MEAS: begin
                    nxt_rx.cnt = rx_ff.cnt + 1'b1;
                    if (fall) begin
                        nxt_rx.edges = rx_ff.edges + 1'b1;
                        if (rx_ff.edges == SYNC_EDGES - 3'h1) begin
                            nxt_rx.bitLen = rx_ff.cnt[MEAS_W-1:3]; // RL8
                            nxt_rx.st = (rx_ff.cnt[MEAS_W-1:4] == '0) ? RX_HUNT : RX_STOPWAIT;
                        end
                    end
                end
                RX_STOPWAIT: begin
                    if (rxLine) begin
                        nxt_rx.st = RX_IDLE;
                        nxt_rx.locked = 1'b1;
                    end
                end
                RX_IDLE: begin
                    if (fall) begin
                        nxt_rx.st = RX_HALF;
                        nxt_rx.cnt = '0;
                    end
                end
                RX_HALF: begin
                    nxt_rx.cnt = rx_ff.cnt + 1'b1;
                    if (rx_ff.cnt == {4'h0, rx_ff.bitLen[BIT_W-1:1]}) begin
                        // A glitch shorter than half a bit is not a start bit
                        nxt_rx.st = rxLine ? RX_IDLE : RX_BITS; // RL21
                        nxt_rx.cnt = '0;
                        nxt_rx.bitCnt = 4'h0;
                    end
                end
                RX_BITS: begin
                    nxt_rx.cnt = rx_ff.cnt + 1'b1;
                    if (rx_ff.cnt == bitFull - 1'b1) begin
                        nxt_rx.cnt = '0;
                        nxt_rx.shift = {rxLine, rx_ff.shift[7:1]}; // RL21
                        nxt_rx.bitCnt = rx_ff.bitCnt + 1'b1;
                        if (rx_ff.bitCnt == 4'h7) begin
                            nxt_rx.st = RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    nxt_rx.cnt = rx_ff.cnt + 1'b1;
                    if (rx_ff.cnt == bitFull - 1'b1) begin
                        // Framing error drops the byte silently
                        nxt_rx.valid = rxLine;
                        nxt_rx.data = rx_ff.shift;
                        nxt_rx.st = RX_IDLE;
                    end
                end
                default: nxt_rx.st = RX_HUNT;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rx_ff <= '{st: RX_HUNT, prevLine: 1'b1, default: '0};
        end else begin
            rx_ff <= nxt_rx;
        end
    end

    assign byteValid = rx_ff.valid;
    assign byteData = rx_ff.data;
    assign locked = rx_ff.locked;
    assign bitLen = rx_ff.bitLen;
endmodule : sync_byte_rx

//--- hdl/serial_frame_slave_decoder.sv
/*
  Slave decoder for the framed single-wire register protocol, with an APB
  slave for its own settings and a byte-wide port to the register file.
  Assumes regRdData is valid in the same cycle that regRdEn is high, and
  that the line transceiver keeps the pin high when nothing drives it.
*/
// Chosen here: the APB interface to the registers and the address map.
// Summary of operation
// RL1 - Select bit set: use stored address
// RL2 - Select bit clear: use address pins
// RL3 - Stored slave address resets to zero
// RL4 - Each slave on bus gets unique address
// RL5 - Status byte and CRC only after CRC
// RL6 - Response enable low suppresses response
// RL7 - Broadcast frames never answered
// RL8 - Sync byte 55h sets bit timing
// RL9 - Master sends fresh sync every transaction
// RL10 - Select byte low nibble is target
// RL11 - Length code gives 1/4/16/24 bytes
// RL12 - Broadcast only with target address zero
// RL13 - Bit 7 direction; broadcast only writes
// RL14 - Byte after select is register address
// RL15 - Take exactly length payload bytes, then CRC
// RL16 - Master CRCs select, address, payload bytes
// RL17 - CRC mismatch drops frame, no watchdog clear
// RL18 - CRC starts from all ones
// RL19 - Burst write increments register address
// RL20 - Burst read increments register address
// RL21 - Start, eight data LSB first, stop
// RL22 - Idle timeout mid-frame abandons frame
// RL23 - Read returns data, then status
// RL24 - Good frame clears link watchdog
// RL25 - Foreign address frames ignored silently
// RL26 - CRC polynomial is a parameter
`timescale 1ns/10ps
module serial_frame_slave_decoder
    import sfd_pkg::*;
#(
    parameter logic [7:0] CRC_POLY = CRC_POLY_DEFAULT, // RL26
    parameter int IDLE_UNIT = IDLE_UNIT_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial line and address pins
    input wire logic rxPin,
    output logic txPin,
    input wire logic slaveAddrPin3,
    input wire logic slaveAddrPin2,
    input wire logic slaveAddrPin1,
    input wire logic slaveAddrPin0,
    // Register file and status
    output logic [7:0] regAddr,
    output logic regWrEn,
    output logic [7:0] regWrData,
    output logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic [7:0] flagErr,
    output logic linkWdClear
);
    typedef enum logic [3:0] {F_HUNT, F_SEL, F_REG, F_DATA, F_CRC, F_WRITE, F_FETCH, F_LOAD,
        F_SEND, F_DONE} frame_state_t;

    typedef struct packed {
        frame_state_t st;
        logic rxMeta;
        logic rxSync;
        logic rxPrev;
        logic [3:0] pinMeta;
        logic [3:0] pinSync;
        logic [IDLE_W-1:0] idleCnt;
        logic [7:0] selByte;
        logic [7:0] regBase;
        logic [4:0] count;
        logic [4:0] idx;
        logic [MAX_PAYLOAD-1:0][7:0] payload;
        logic [7:0] crc;
        logic accept;
        logic bcast;
        logic [1:0] step;
        logic [9:0] txShift;
        logic [3:0] txBits;
        logic [BIT_W-1:0] txCnt;
        logic rxRestart;
        logic addrSrc;
        logic [3:0] slvAddr;
        logic rspEn;
        logic [3:0] idleSet;
        logic [7:0] okCnt;
        logic [7:0] crcErrCnt;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [7:0] regAddr;
        logic regWrEn;
        logic [7:0] regWrData;
        logic regRdEn;
        logic wdClr;
        logic txOut;
    } dec_regs_t;

    dec_regs_t dec_ff;
    dec_regs_t nxt_dec;

    logic rxValid;
    logic [7:0] rxByte;
    logic rxLocked;
    logic [BIT_W-1:0] bitLen;
    logic [3:0] effAddr;
    logic [IDLE_W-1:0] idleLimit;
    logic inFrame;
    logic isBcast;
    logic [7:0] txByte;
    logic [7:0] crcIn;

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] x;
        x = c ^ d;
        for (int i = 0; i < 8; i++) begin
            x = x[7] ? ({x[6:0], 1'b0} ^ CRC_POLY) : {x[6:0], 1'b0};
        end
        return x;
    endfunction : crc8

    sync_byte_rx u_rx (
        .mclk(mclk),
        .arst_n(arst_n),
        .rxLine(dec_ff.rxSync),
        .restart(dec_ff.rxRestart),
        .byteValid(rxValid),
        .byteData(rxByte),
        .locked(rxLocked),
        .bitLen(bitLen)
    );

    always_comb begin
        nxt_dec = dec_ff;
        effAddr = dec_ff.addrSrc ? dec_ff.slvAddr : dec_ff.pinSync; // RL1 RL2
        idleLimit = IDLE_W'((int'(dec_ff.idleSet) + 1) * IDLE_UNIT);
        inFrame = dec_ff.st inside {F_HUNT, F_SEL, F_REG, F_DATA, F_CRC};
        crcIn = dec_ff.crc;
        isBcast = rxByte[SEL_BCAST_BIT] && rxByte[SEL_WRITE_BIT]
            && rxByte[SEL_ADDR_LSB +: 4] == BCAST_ADDR; // RL12 RL13
        case (dec_ff.step)
            2'h0: txByte = regRdData;
            2'h1: txByte = flagErr;
            default: txByte = dec_ff.crc;
        endcase

        // Pin synchronisers
        nxt_dec.rxMeta = rxPin;
        nxt_dec.rxSync = dec_ff.rxMeta;
        nxt_dec.rxPrev = dec_ff.rxSync;
        nxt_dec.pinMeta = {slaveAddrPin3, slaveAddrPin2, slaveAddrPin1, slaveAddrPin0};
        nxt_dec.pinSync = dec_ff.pinMeta;

        nxt_dec.regWrEn = 1'b0;
        nxt_dec.regRdEn = 1'b0;
        nxt_dec.wdClr = 1'b0;

        // Idle watch restarts on line toggles; done keeps it so hunt fires once
        if (dec_ff.rxSync != dec_ff.rxPrev || !(inFrame || dec_ff.st == F_DONE)) begin
            nxt_dec.idleCnt = '0;
        end else if (dec_ff.idleCnt != idleLimit) begin
            nxt_dec.idleCnt = dec_ff.idleCnt + 1'b1;
        end

        case (dec_ff.st)
            F_HUNT: begin
                if (rxLocked && !dec_ff.rxRestart) begin
                    nxt_dec.st = F_SEL;
                    nxt_dec.crc = CRC_INIT; // RL18
                end
            end
            F_SEL: begin
                if (rxValid) begin
                    nxt_dec.selByte = rxByte; // RL10
                    nxt_dec.crc = crc8(crcIn, rxByte);
                    nxt_dec.bcast = isBcast; // RL12
                    nxt_dec.accept = isBcast || rxByte[SEL_ADDR_LSB +: 4] == effAddr; // RL25
                    nxt_dec.st = F_REG;
                end
            end
            F_REG: begin
                if (rxValid) begin
                    nxt_dec.regBase = rxByte; // RL14
                    nxt_dec.crc = crc8(crcIn, rxByte);
                    nxt_dec.count = payload_len(dec_ff.selByte[SEL_LEN_LSB +: 2]); // RL11
                    nxt_dec.idx = 5'h0;
                    nxt_dec.st = dec_ff.selByte[SEL_WRITE_BIT] ? F_DATA : F_CRC; // RL13
                end
            end
            F_DATA: begin
                if (rxValid) begin
                    nxt_dec.payload[dec_ff.idx] = rxByte;
                    nxt_dec.crc = crc8(crcIn, rxByte);
                    nxt_dec.idx = dec_ff.idx + 1'b1;
                    if (dec_ff.idx == dec_ff.count - 1'b1) begin
                        nxt_dec.st = F_CRC; // RL15
                    end
                end
            end
            F_CRC: begin
                if (rxValid) begin
                    nxt_dec.idx = 5'h0;
                    nxt_dec.step = 2'h0;
                    if (rxByte != dec_ff.crc) begin
                        nxt_dec.crcErrCnt = dec_ff.crcErrCnt + 1'b1;
                        nxt_dec.st = F_DONE; // RL17
                    end else if (!dec_ff.accept) begin
                        nxt_dec.st = F_DONE; // RL25
                    end else begin
                        nxt_dec.wdClr = 1'b1; // RL24
                        nxt_dec.okCnt = dec_ff.okCnt + 1'b1;
                        nxt_dec.crc = CRC_INIT; // RL18
                        nxt_dec.st = dec_ff.selByte[SEL_WRITE_BIT] ? F_WRITE : F_FETCH;
                    end
                end
            end
            F_WRITE: begin
                nxt_dec.regWrEn = 1'b1;
                nxt_dec.regAddr = dec_ff.regBase + {3'h0, dec_ff.idx}; // RL19
                nxt_dec.regWrData = dec_ff.payload[dec_ff.idx];
                nxt_dec.idx = dec_ff.idx + 1'b1;
                if (dec_ff.idx == dec_ff.count - 1'b1) begin
                    nxt_dec.step = 2'h1;
                    nxt_dec.st = (dec_ff.rspEn && !dec_ff.bcast) ? F_LOAD : F_DONE; // RL5 RL6 RL7
                end
            end
            F_FETCH: begin
                if (!dec_ff.rspEn) begin
                    nxt_dec.st = F_DONE; // RL6
                end else begin
                    nxt_dec.regRdEn = 1'b1;
                    nxt_dec.regAddr = dec_ff.regBase + {3'h0, dec_ff.idx}; // RL20
                    nxt_dec.st = F_LOAD;
                end
            end
            F_LOAD: begin
                nxt_dec.txShift = {1'b1, txByte, 1'b0}; // RL21
                nxt_dec.txBits = 4'h0;
                nxt_dec.txCnt = '0;
                if (dec_ff.step != 2'h2) begin
                    nxt_dec.crc = crc8(crcIn, txByte);
                end
                nxt_dec.st = F_SEND;
            end
            F_SEND: begin
                nxt_dec.txCnt = dec_ff.txCnt + 1'b1;
                if (dec_ff.txCnt == bitLen - 1'b1) begin
                    nxt_dec.txCnt = '0;
                    nxt_dec.txShift = {1'b1, dec_ff.txShift[9:1]};
                    nxt_dec.txBits = dec_ff.txBits + 1'b1;
                    if (dec_ff.txBits == 4'h9) begin
                        // Data bytes first, then status, then CRC
                        nxt_dec.st = F_LOAD; // RL23
                        if (dec_ff.step == 2'h0) begin
                            nxt_dec.idx = dec_ff.idx + 1'b1;
                            if (dec_ff.idx == dec_ff.count - 1'b1) begin
                                nxt_dec.step = 2'h1;
                            end else begin
                                nxt_dec.st = F_FETCH; // RL20
                            end
                        end else if (dec_ff.step == 2'h1) begin
                            nxt_dec.step = 2'h2; // RL5
                        end else begin
                            nxt_dec.st = F_DONE;
                        end
                    end
                end
            end
            F_DONE: begin
                nxt_dec.st = F_HUNT; // RL9
            end
            default: nxt_dec.st = F_DONE;
        endcase

        if (inFrame && dec_ff.idleCnt != idleLimit && nxt_dec.idleCnt == idleLimit) begin
            nxt_dec.st = F_DONE; // RL22
        end
        // Receiver held off while answering so our own echo is not parsed
        nxt_dec.rxRestart = nxt_dec.st inside {F_WRITE, F_FETCH, F_LOAD, F_SEND, F_DONE};
        nxt_dec.txOut = (nxt_dec.st == F_SEND) ? nxt_dec.txShift[0] : 1'b1;

        // APB: data prepared in setup, answered in the first access cycle
        nxt_dec.pready = psel && !penable;
        if (psel && !penable) begin
            nxt_dec.pslverr = !(paddr inside {CTRL_OFS, STAT_OFS, CNT_OFS});
            case (paddr)
                CTRL_OFS: nxt_dec.prdata = {16'h0000, dec_ff.idleSet, 3'h0, dec_ff.rspEn,
                    dec_ff.slvAddr, 3'h0, dec_ff.addrSrc};
                STAT_OFS: nxt_dec.prdata = {1'b0, bitLen, 8'h00, 2'h0, !inFrame,
                    rxLocked, effAddr};
                CNT_OFS: nxt_dec.prdata = {16'h0000, dec_ff.okCnt, dec_ff.crcErrCnt};
                default: nxt_dec.prdata = 32'h0000_0000;
            endcase
        end else begin
            nxt_dec.pslverr = 1'b0;
        end
        if (psel && penable && dec_ff.pready && pwrite && paddr == CTRL_OFS) begin
            nxt_dec.addrSrc = pwdata[CTRL_ADDRSRC_BIT];
            nxt_dec.slvAddr = pwdata[CTRL_SLVADDR_LSB +: 4];
            nxt_dec.rspEn = pwdata[CTRL_RSPEN_BIT]; // RL6
            nxt_dec.idleSet = pwdata[CTRL_IDLE_LSB +: 4];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            dec_ff <= '{st: F_HUNT, rxMeta: 1'b1, rxSync: 1'b1, rxPrev: 1'b1,
                crc: CRC_INIT, addrSrc: ADDRSRC_RST, slvAddr: SLVADDR_RST, // RL3
                rspEn: RSPEN_RST, idleSet: IDLE_RST, txOut: 1'b1, rxRestart: 1'b1,
                default: '0};
        end else begin
            dec_ff <= nxt_dec;
        end
    end

    assign prdata = dec_ff.prdata;
    assign pready = dec_ff.pready;
    assign pslverr = dec_ff.pslverr;
    assign txPin = dec_ff.txOut;
    assign regAddr = dec_ff.regAddr;
    assign regWrEn = dec_ff.regWrEn;
    assign regWrData = dec_ff.regWrData;
    assign regRdEn = dec_ff.regRdEn;
    assign linkWdClear = dec_ff.wdClr;
endmodule : serial_frame_slave_decoder

//--- tb/serial_frame_slave_decoder_sva.sv
/*
  Port checker for the frame decoder: APB timing, strobes, reply order.
  Assumes one clock domain; bound onto the decoder below.
*/
`timescale 1ns/10ps
module serial_frame_slave_decoder_sva
    import sfd_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Link and register side
    input wire logic txPin,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic linkWdClear
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    apb_answer_a: assert property (psel && !penable |=> pready)
        else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready too long");
    err_quiet_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("pslverr without ready or with data");
    unmapped_err_a: assert property (psel && penable && pready && paddr > CNT_OFS |-> pslverr)
        else $error("unmapped access not refused");
    burst_step_a: assert property (regWrEn && $past(regWrEn) |-> regAddr == $past(regAddr) + 8'h01)
        else $error("burst address not incremented");
    wr_after_crc_a: assert property ($rose(regWrEn) |-> $past(linkWdClear))
        else $error("write without checked frame");
    wr_before_tx_a: assert property (regWrEn |-> txPin throughout regWrEn [*1])
        else $error("reply during write strobes");
    wd_pulse_a: assert property (linkWdClear |=> !linkWdClear [*2])
        else $error("watchdog clear not a pulse");
endmodule : serial_frame_slave_decoder_sva

bind serial_frame_slave_decoder serial_frame_slave_decoder_sva CHK (
    .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .txPin(txPin),
    .regAddr(regAddr), .regWrEn(regWrEn), .linkWdClear(linkWdClear));

//--- tb/sfd_master_model.sv
/*
  Link master model: sends bytes on the slave's line, collects replies.
  Assumes an idle-high line and a fixed bit time in clock cycles.
*/
`timescale 1ns/10ps
module sfd_master_model #(
    parameter int BIT = 20
) (
    // Clock
    input wire logic mclk,
    // Line
    output logic rxLine,
    input wire logic txLine
);
    logic [7:0] rxq[$];
    initial rxLine = 1'b1;
    task automatic sendb(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk);
            rxLine <= f[i];
            repeat (BIT - 1) @(posedge mclk);
        end
    endtask : sendb
    // Background capture, since a reply may start before sendb returns
    initial begin
        logic [7:0] v;
        forever begin
            @(negedge txLine);
            repeat (BIT / 2) @(posedge mclk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge mclk);
                v[i] = txLine;
            end
            repeat (BIT) @(posedge mclk);
            rxq.push_back(v);
        end
    end
    task automatic recvb(output logic [7:0] b, output bit g);
        for (int k = 0; k < 900 && rxq.size() == 0; k++) @(posedge mclk);
        g = rxq.size() > 0;
        b = g ? rxq.pop_front() : 8'hXX;
    endtask : recvb
endmodule : sfd_master_model

//--- tb/serial_frame_slave_decoder_tb.sv
/*
  Testbench: APB settings and framed link traffic through a master model,
  with a byte register file behind the decoder.
  Assumes the model's bit time fits the shortened idle timeout.
*/
`timescale 1ns/10ps
module serial_frame_slave_decoder_tb
    import sfd_pkg::*;
;
    logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, txPin, rxPin;
    logic regWrEn, regRdEn, linkWdClear;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pins;
    logic [7:0] regAddr, regWrData, regRdData, flags, fill;
    logic [7:0] mem[256], shadow[256];
    int fails, compares, rdN, wdN;
    int lens[4] = '{1, 4, 16, 24};

    serial_frame_slave_decoder #(.CRC_POLY(CRC_POLY_DEFAULT), .IDLE_UNIT(50)) DUT (
        .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxPin(rxPin), .txPin(txPin), .slaveAddrPin3(pins[3]),
        .slaveAddrPin2(pins[2]), .slaveAddrPin1(pins[1]), .slaveAddrPin0(pins[0]),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData(regRdData), .flagErr(flags), .linkWdClear(linkWdClear));
    sfd_master_model #(.BIT(20)) MCU (.mclk(mclk), .rxLine(rxPin), .txLine(txPin));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    assign regRdData = mem[regAddr];
    always @(posedge mclk) if (regWrEn === 1'b1) mem[regAddr] <= regWrData;
    always @(posedge mclk) begin
        rdN <= rdN + int'(regRdEn === 1'b1);
        wdN <= wdN + int'(linkWdClear === 1'b1);
    end

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        for (int i = 7; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? CRC_POLY_DEFAULT : 8'h00);
        return c;
    endfunction : crc8
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
        compares++;
        if (y !== x) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, x, y);
        end
    endtask : chk
    task print_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int k;
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        r = {prdata[31:1], prdata[0] | pslverr};
        {psel, penable} <= 2'b00;
        if (pready !== 1'b1) begin
            fails++;
            print_verdict();
        end
    endtask : apb
    // Sends one frame, then checks the reply and the whole register file
    task automatic frm(input logic [7:0] s, ra, input bit bad, rsp, take);
        logic [7:0] c, d;
        bit g;
        int n, r0, w0;
        n = lens[s[5:4]];
        r0 = rdN;
        w0 = wdN;
        MCU.sendb(SYNC_PATTERN);
        MCU.sendb(s);
        MCU.sendb(ra);
        c = crc8(crc8(CRC_INIT, s), ra);
        for (int i = 0; i < n && s[7]; i++) begin
            d = fill + 8'(i);
            MCU.sendb(d);
            c = crc8(c, d);
            if (take) shadow[8'(ra + i)] = d;
        end
        MCU.sendb(bad ? ~c : c);
        c = CRC_INIT;
        for (int i = 0; i < n && rsp && !s[7]; i++) begin
            MCU.recvb(d, g);
            chk("rdata", shadow[8'(ra + i)], d);
            c = crc8(c, d);
        end
        MCU.recvb(d, g);
        if (rsp) begin
            chk("status", flags, d);
            MCU.recvb(d, g);
            chk("reply crc", crc8(c, flags), d);
        end else chk("silent", 0, g);
        repeat (300) @(posedge mclk);
        chk("rd strobes", (rsp && !s[7]) ? n : 0, rdN - r0);
        chk("wd clear", !bad && (rsp || take), wdN - w0);
        for (int i = 0; i < 256; i++) chk("reg", shadow[i], mem[i]);
        fill = fill + 8'h11;
    endtask : frm

    initial begin
        logic [31:0] r;
        {psel, penable, pwrite, paddr, pwdata, arst_n} = '0;
        pins = 4'h5;
        flags = 8'h5A;
        fill = 8'h30;
        for (int i = 0; i < 256; i++) {mem[i], shadow[i]} = 16'h0000;
        repeat (20) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        apb(0, CTRL_OFS, 0, r);
        chk("ctrl", 32'h0000_3100, r);
        apb(0, STAT_OFS, 0, r);
        chk("addr", 5, r & 32'hF);
        apb(0, 12'h00C, 0, r);
        chk("unmapped", 1, r); // prdata zero, error in bit 0
        $display("test regs done");
        for (int k = 0; k < 4; k++) frm({2'b10, 2'(k), 4'h5}, 8'h20, 0, 1, 1);
        frm(8'h95, 8'hFE, 0, 1, 1);
        for (int k = 0; k < 4; k++) frm({2'b00, 2'(k), 4'h5}, 8'h20, 0, 1, 0);
        $display("test frames done");
        frm(8'h85, 8'h40, 1, 0, 0);
        frm(8'h86, 8'h40, 0, 0, 0);
        frm(8'hC0, 8'h41, 0, 0, 1);
        frm(8'hC5, 8'h42, 0, 1, 1);
        MCU.sendb(SYNC_PATTERN);
        MCU.sendb(8'h85);
        repeat (400) @(posedge mclk);
        frm(8'h85, 8'h43, 0, 1, 1);
        $display("test faults done");
        apb(1, CTRL_OFS, 32'h0000_3191, r);
        pins <= 4'hA;
        apb(0, STAT_OFS, 0, r);
        chk("addr", 9, r & 32'hF);
        chk("bit len", 20, r[30:16]);
        frm(8'h89, 8'h44, 0, 1, 1);
        frm(8'h8A, 8'h44, 0, 0, 0);
        apb(1, CTRL_OFS, 32'h0000_3091, r);
        frm(8'h89, 8'h45, 0, 0, 1);
        $display("test addressing done");
        print_verdict();
    end
endmodule : serial_frame_slave_decoder_tb
